// File: pkg/oat_pkg.sv
// package: register map, field layout and reset values for the amplifier trim control
package oat_pkg;

   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [11:0] OFS_AMP_CONTROL  = 12'h000; // amplifier control word
   localparam logic [11:0] OFS_AMP_OFFCAL   = 12'h004; // offset calibration word

   // ****************************************
   // field positions
   // ****************************************
   localparam int BIT_BANDWIDTH   = 0;  // profile select
   localparam int BIT_CAL_OUTPUT  = 1;  // read-only comparator state
   localparam int BIT_AMP_ENABLE  = 2;  // amplifier on/off
   localparam int BIT_CAL_MODE    = 7;  // normal / calibration
   localparam int BIT_CAL_REF     = 6;  // reference input select
   localparam int TRIM_MSB        = 5;  // trim field top bit
   localparam int TRIM_W          = 6;  // trim field width

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RST_AMP_CONTROL = 8'h00; // all control bits clear
   localparam logic [7:0] RST_AMP_OFFCAL  = 8'h20; // trim starts at mid-scale code

   // ****************************************
   // ahb-lite encodings
   // ****************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // single transfer start
   localparam logic [1:0] HTRANS_SEQ    = 2'h3; // burst continuation
   localparam logic [1:0] HRESP_OKAY    = 2'h0; // only response given

   // ****************************************
   // carriers
   // ****************************************
   // analog control lines towards the amplifier
   typedef struct packed {
      logic                enable;     // amplifier powered
      logic                highBw;     // 1 = high bandwidth
      logic                calMode;    // 1 = offset calibration
      logic                calRefPos;  // 1 = non-inverting reference
      logic [TRIM_W-1:0]   trim;       // offset trim code
   } oat_analog_t;

   // latched address phase
   typedef struct packed {
      logic                valid;      // a transfer is pending
      logic                write;      // direction
      logic [11:0]         addr;       // byte address
   } oat_addr_t;

endpackage

// File: rtl/oat_sync.sv
// two-flop synchroniser for a level coming from the analog side
module oat_sync
   import oat_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // level in and out
   input  wire logic asyncIn,
   output logic      syncOut
);

   // ****************************************
   // synchroniser stages
   // ****************************************
   logic stage1_ff; // first stage, read only by second stage

   // plain two-flop chain; metastability settles in stage one
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_ff <= 1'b0;
         syncOut   <= 1'b0;
      end else begin
         stage1_ff <= asyncIn;
         syncOut   <= stage1_ff;
      end
   end

endmodule

// File: rtl/oat_ahb_slave.sv
// ahb-lite slave front end: latches the address phase; ready and response come from the register bank
module oat_ahb_slave
   import oat_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // ahb-lite address phase
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   // latched request towards the register file
   output oat_addr_t        pend
);

   // ****************************************
   // address phase capture
   // ****************************************
   logic takeIt; // a valid transfer is accepted this edge

   // only nonseq/seq while the bus is ready start a data phase
   assign takeIt = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

   // hold the address phase for the following data phase; hsize is always a word
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend <= '0;
      end else if (hready) begin
         pend.valid <= takeIt;
         pend.write <= hwrite;
         pend.addr  <= haddr;
      end
   end

endmodule

// File: rtl/oat_trim_ctrl.sv
// amplifier offset trim control: register bank behind an ahb-lite slave
// What this block does
// - enable bit two powers amplifier, else hi-z
// - bit one reads comparator output in calibration
// - bit zero picks low current or bandwidth
// - control bits seven to three read zero
// - calibration bit seven selects calibration mode
// - bit six selects calibration reference input
// - six-bit trim field writable and held
//
// The AHB-Lite register port and the address map are this design's own decisions.
module oat_trim_ctrl
   import oat_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic [1:0]       hresp,
   // analog amplifier side
   input  wire logic        ampOutputPin,
   output oat_analog_t      ampCtrl,
   output logic             ampOutputOe
);

   // ****************************************
   // register storage
   // ****************************************
   logic                ampEnable_ff;     // amplifier on
   logic                bandwidthSel_ff;  // 1 = high bandwidth
   logic                calModeSel_ff;    // 1 = calibration mode
   logic                calRefSel_ff;     // 1 = non-inverting reference
   logic [TRIM_W-1:0]   offsetTrim_ff;    // offset trim field
   oat_addr_t           pend;             // latched address phase
   logic                ampOutSync;       // comparator state, synchronised
   logic                calOutputFlag;    // value shown in bit one
   logic [7:0]          ctlImage;         // control byte as a read would see it
   logic [7:0]          calImage;         // calibration byte as a read would see it
   logic                curTake;          // a transfer starts on the bus this edge
   oat_addr_t           curPhase;         // address phase now on the bus
   logic                wrCtl;            // write strobe, control word
   logic                wrCal;            // write strobe, calibration word

   // ****************************************
   // sub-blocks
   // ****************************************
   // bus front end latches the address phase
   oat_ahb_slave u_slave (
      .clk     (clk),
      .reset_n (reset_n),
      .hsel    (hsel),
      .haddr   (haddr),
      .htrans  (htrans),
      .hwrite  (hwrite),
      .hsize   (hsize),
      .hready  (hready),
      .pend    (pend)
   );

   // comparator output is asynchronous to clk
   oat_sync u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .asyncIn (ampOutputPin),
      .syncOut (ampOutSync)
   );

   // ****************************************
   // decode
   // ****************************************
   // match a latched address against one register
   function automatic logic hit(input oat_addr_t p, input logic [11:0] ofs);
      hit = p.valid && (p.addr[11:2] == ofs[11:2]);
   endfunction

   assign wrCtl = hit(pend, OFS_AMP_CONTROL) && pend.write;
   assign wrCal = hit(pend, OFS_AMP_OFFCAL) && pend.write;

   // ****************************************
   // control register
   // ****************************************
   // only bits two and zero are stored; bit one and upper bits drop writes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ampEnable_ff    <= RST_AMP_CONTROL[BIT_AMP_ENABLE];
         bandwidthSel_ff <= RST_AMP_CONTROL[BIT_BANDWIDTH];
      end else if (wrCtl) begin
         ampEnable_ff    <= hwdata[BIT_AMP_ENABLE];
         bandwidthSel_ff <= hwdata[BIT_BANDWIDTH];
      end
   end

   // ****************************************
   // calibration register
   // ****************************************
   // mode, reference and trim all writable at any time; software orders them
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         calModeSel_ff <= RST_AMP_OFFCAL[BIT_CAL_MODE];
         calRefSel_ff  <= RST_AMP_OFFCAL[BIT_CAL_REF];
         offsetTrim_ff <= RST_AMP_OFFCAL[TRIM_MSB:0];
      end else if (wrCal) begin
         calModeSel_ff <= hwdata[BIT_CAL_MODE];
         calRefSel_ff  <= hwdata[BIT_CAL_REF];
         offsetTrim_ff <= hwdata[TRIM_MSB:0];
      end
   end

   // ****************************************
   // read path
   // ****************************************
   // comparator state only has meaning in calibration; otherwise read zero
   assign calOutputFlag = calModeSel_ff & ampOutSync;

   // the address phase on the bus right now, in the shape of the latched one
   assign curTake  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   assign curPhase = '{valid: curTake, write: hwrite, addr: haddr};

   // register images as a read will see them, a write landing this edge included;
   // forwarding lets a read issued right behind a write return the new value
   always_comb begin
      ctlImage                 = 8'h00;
      ctlImage[BIT_AMP_ENABLE] = wrCtl ? hwdata[BIT_AMP_ENABLE] : ampEnable_ff;
      ctlImage[BIT_CAL_OUTPUT] = calOutputFlag;
      ctlImage[BIT_BANDWIDTH]  = wrCtl ? hwdata[BIT_BANDWIDTH] : bandwidthSel_ff;
      if (wrCal) begin
         calImage = hwdata[7:0];                        // pending write wins
      end else begin
         calImage = {calModeSel_ff, calRefSel_ff, offsetTrim_ff};
      end
   end

   // read data launched at the address-phase edge, so it leaves a flop and
   // stands for the whole data phase; anything but a mapped read gives zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata <= 32'h0000_0000;
      end else if (hready) begin
         if (hit(curPhase, OFS_AMP_CONTROL) && !hwrite) begin
            hrdata <= {24'h00_0000, ctlImage};
         end else if (hit(curPhase, OFS_AMP_OFFCAL) && !hwrite) begin
            hrdata <= {24'h00_0000, calImage};
         end else begin
            hrdata <= 32'h0000_0000;                    // write, idle or unmapped
         end
      end
   end

   // zero-wait okay answer, kept in flops so every port leaves a register;
   // the bench still compares it, so a stuck ready shows up as a hang
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

   // ****************************************
   // analog outputs
   // ****************************************
   // registered drive to the amplifier; trim stays in normal mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ampCtrl     <= '0;
         ampOutputOe <= 1'b0;
      end else begin
         ampCtrl.enable    <= ampEnable_ff;
         ampCtrl.highBw    <= bandwidthSel_ff;
         ampCtrl.calMode   <= calModeSel_ff;
         ampCtrl.calRefPos <= calRefSel_ff;
         ampCtrl.trim      <= offsetTrim_ff;
         ampOutputOe       <= ampEnable_ff;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   // the analog copies lag the registers by one edge and are still in reset at
   // the first edge after release, hence the sampled reset in their antecedents
   ctl_write_lands_a: assert property (@(posedge clk) disable iff (!reset_n)
      wrCtl |=> ampEnable_ff == $past(hwdata[BIT_AMP_ENABLE])
                && bandwidthSel_ff == $past(hwdata[BIT_BANDWIDTH]))
      else $error("control write not stored");
   hiz_when_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !ampEnable_ff |=> !ampOutputOe)
      else $error("output driven while disabled");
   enable_drives_a: assert property (@(posedge clk) disable iff (!reset_n)
      ampEnable_ff ##1 ampEnable_ff |-> ampOutputOe && ampCtrl.enable)
      else $error("enabled amplifier not driven");
   upper_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      hit(pend, OFS_AMP_CONTROL) |-> hrdata[31:3] == 29'h0)
      else $error("reserved control bits not zero");
   ctl_read_match_a: assert property (@(posedge clk) disable iff (!reset_n)
      hit(pend, OFS_AMP_CONTROL) && !pend.write
      |-> hrdata[BIT_AMP_ENABLE] == ampEnable_ff && hrdata[BIT_BANDWIDTH] == bandwidthSel_ff)
      else $error("control read data wrong");
   flag_follows_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
      calModeSel_ff && $stable(calModeSel_ff) ##0 $past(ampOutputPin, 2) == ampOutSync
      |-> calOutputFlag == $past(ampOutputPin, 2))
      else $error("calibration flag does not follow pin");
   flag_quiet_normal_a: assert property (@(posedge clk) disable iff (!reset_n)
      !calModeSel_ff |-> !calOutputFlag)
      else $error("flag set outside calibration");
   cal_write_lands_a: assert property (@(posedge clk) disable iff (!reset_n)
      wrCal |=> {calModeSel_ff, calRefSel_ff, offsetTrim_ff} == $past(hwdata[7:0]))
      else $error("calibration write not stored");
   cal_read_match_a: assert property (@(posedge clk) disable iff (!reset_n)
      hit(pend, OFS_AMP_OFFCAL) && !pend.write
      |-> hrdata == {24'h00_0000, calModeSel_ff, calRefSel_ff, offsetTrim_ff})
      else $error("calibration read data wrong");
   trim_holds_a: assert property (@(posedge clk) disable iff (!reset_n)
      !wrCal |=> $stable(offsetTrim_ff))
      else $error("trim changed without write");
   trim_reaches_amp_a: assert property (@(posedge clk) disable iff (!reset_n)
      $past(reset_n) |-> ampCtrl.trim == $past(offsetTrim_ff)
                         && ampCtrl.calMode == $past(calModeSel_ff))
      else $error("trim not passed to amplifier");
   ref_reaches_amp_a: assert property (@(posedge clk) disable iff (!reset_n)
      $past(reset_n) |-> ampCtrl.calRefPos == $past(calRefSel_ff)
                         && ampCtrl.highBw == $past(bandwidthSel_ff))
      else $error("reference or profile not passed to amplifier");
   ro_bit_ignored_a: assert property (@(posedge clk) disable iff (!reset_n)
      wrCtl && !calModeSel_ff |=> !calOutputFlag)
      else $error("read-only bit took a write");
   unmapped_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
      pend.valid && pend.write && !wrCtl && !wrCal
      |=> $stable({ampEnable_ff, bandwidthSel_ff, calModeSel_ff, calRefSel_ff, offsetTrim_ff}))
      else $error("unmapped write changed a register");

   cal_entry_c: cover property (@(posedge clk) disable iff (!reset_n)
      wrCal && hwdata[BIT_CAL_MODE] && hwdata[BIT_CAL_REF]);
   flag_toggle_c: cover property (@(posedge clk) disable iff (!reset_n)
      calModeSel_ff && $changed(calOutputFlag));
   back_normal_c: cover property (@(posedge clk) disable iff (!reset_n)
      $fell(calModeSel_ff) ##1 ampEnable_ff);
   search_read_c: cover property (@(posedge clk) disable iff (!reset_n)
      hit(pend, OFS_AMP_CONTROL) && !pend.write && hrdata[BIT_CAL_OUTPUT]);

endmodule

// File: test/test_opamp_offset_trim_control.sv
// testbench for the amplifier offset trim register bank
module test_opamp_offset_trim_control
   import oat_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // signals and design instance
   // ****************************************
   localparam logic [5:0] TRIP  = 6'h16;  // comparator trip code of the modelled amplifier
   localparam int         LIMIT = 20000;  // cycle ceiling, whole run needs about 600

   logic              clk       = 1'b0;   // 25 MHz system clock
   logic              reset_n   = 1'b0;   // async reset, held at start
   logic              hsel      = 1'b0;   // slave select
   logic [11:0]       haddr     = 12'h000;
   logic [1:0]        htrans    = 2'h0;   // idle at start
   logic              hwrite    = 1'b0;
   logic [2:0]        hsize     = 3'h2;   // whole words only
   logic [31:0]       hwdata    = 32'h0;
   logic [31:0]       hrdata;
   logic              hreadyout;
   logic              hready;
   logic [1:0]        hresp;
   logic              ampOutputPin = 1'b0; // modelled comparator output
   oat_analog_t       ampCtrl;
   logic              ampOutputOe;
   int                n_fail      = 0;    // mismatches seen
   int                comparisons = 0;    // compares made
   int                cycles      = 0;    // timeout counter

   assign hready = hreadyout;  // one slave, its ready is the bus ready

   oat_trim_ctrl i_dut (
      .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ampOutputPin(ampOutputPin),
      .ampCtrl(ampCtrl), .ampOutputOe(ampOutputOe));

   always #20 clk = ~clk;

   // comparator flips once the trim code reaches the trip point
   always @(posedge clk) begin
      ampOutputPin <= (ampCtrl.trim >= TRIP);
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one single transfer; entered just after a rising edge
   task automatic busXfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      check("hready hresp", {29'h0, hreadyout, hresp}, {29'h0, 1'b1, HRESP_OKAY});
   endtask

   // ampCtrl two edges after a write, read off the edge
   task automatic checkAmp(input logic [9:0] exp, input logic oe);
      repeat (2) @(posedge clk);
      #1;
      check("ampCtrl", {22'h0, ampCtrl}, {22'h0, exp});
      check("ampOutputOe", {31'h0, ampOutputOe}, {31'h0, oe});
   endtask

   // wait out the two-flop sampling of the output, then read the flag
   task automatic readFlag(output logic flag);
      logic [31:0] rd;
      repeat (4) @(posedge clk);
      busXfer(1'b0, OFS_AMP_CONTROL, 32'h0, rd);
      flag = rd[BIT_CAL_OUTPUT];
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic testRegisters;
      logic [31:0] rd;
      busXfer(1'b0, OFS_AMP_CONTROL, 32'h0, rd);
      check("control reset", rd, 32'h00);
      busXfer(1'b0, OFS_AMP_OFFCAL, 32'h0, rd);
      check("offcal reset", rd, 32'h20);
      // pin is high here, yet bit one must stay clear outside calibration
      busXfer(1'b1, OFS_AMP_CONTROL, 32'hffff_ffff, rd);
      busXfer(1'b0, OFS_AMP_CONTROL, 32'h0, rd);
      check("control all ones", rd, 32'h05);
      checkAmp({1'b1, 1'b1, 1'b0, 1'b0, 6'h20}, 1'b1);
      busXfer(1'b1, OFS_AMP_CONTROL, 32'h0000_0001, rd);
      checkAmp({1'b0, 1'b1, 1'b0, 1'b0, 6'h20}, 1'b0);
      busXfer(1'b1, OFS_AMP_OFFCAL, 32'h0000_0080, rd);
      checkAmp({1'b0, 1'b1, 1'b1, 1'b0, 6'h00}, 1'b0);
      busXfer(1'b1, OFS_AMP_OFFCAL, 32'h0000_007f, rd);
      busXfer(1'b0, OFS_AMP_OFFCAL, 32'h0, rd);
      check("offcal readback", rd, 32'h7f);
      // unmapped word reads zero and leaves the calibration word alone
      busXfer(1'b1, 12'h008, 32'h0000_00ff, rd);
      busXfer(1'b0, 12'h008, 32'h0, rd);
      check("unmapped read", rd, 32'h0);
      busXfer(1'b0, OFS_AMP_OFFCAL, 32'h0, rd);
      check("offcal kept", rd, 32'h7f);
      $display("test registers done");
   endtask

   task automatic testSearch;
      logic [31:0] rd;
      logic        first;
      logic        cur;
      logic [5:0]  code;
      logic [5:0]  lo;
      logic [5:0]  hi;
      logic [6:0]  sum;
      busXfer(1'b1, OFS_AMP_CONTROL, 32'h0000_0004, rd);
      busXfer(1'b1, OFS_AMP_OFFCAL, 32'h0000_0080, rd); // mode first
      busXfer(1'b1, OFS_AMP_OFFCAL, 32'h0000_00c0, rd); // then reference
      code = 6'h00;
      readFlag(first);
      check("flag at zero", {31'h0, first}, 32'h0);
      do begin
         code++;
         busXfer(1'b1, OFS_AMP_OFFCAL, {24'h0, 2'b11, code}, rd);
         readFlag(cur);
      end while (cur === first && code != 6'h3f);
      lo = code;
      check("lower bound", {26'h0, lo}, {26'h0, TRIP});
      code = 6'h3f;
      busXfer(1'b1, OFS_AMP_OFFCAL, 32'h0000_00ff, rd);
      readFlag(first);
      check("flag at top", {31'h0, first}, 32'h1);
      do begin
         code--;
         busXfer(1'b1, OFS_AMP_OFFCAL, {24'h0, 2'b11, code}, rd);
         readFlag(cur);
      end while (cur === first && code != 6'h00);
      hi = code;
      check("upper bound", {26'h0, hi}, {26'h0, TRIP - 6'h1});
      sum = {1'b0, lo} + {1'b0, hi};
      busXfer(1'b1, OFS_AMP_OFFCAL, {24'h0, 2'b11, sum[6:1]}, rd);
      checkAmp({1'b1, 1'b0, 1'b1, 1'b1, 6'h15}, 1'b1);
      busXfer(1'b1, OFS_AMP_OFFCAL, {24'h0, 2'b00, sum[6:1]}, rd);
      busXfer(1'b0, OFS_AMP_OFFCAL, 32'h0, rd);
      check("trim kept", rd, 32'h15);
      checkAmp({1'b1, 1'b0, 1'b0, 1'b0, 6'h15}, 1'b1);
      $display("test search done");
   endtask

   // ****************************************
   // run control
   // ****************************************
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // hang guard: a run past the ceiling counts as a failure
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_fail++;
         finish_test();
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      #1;
      check("oe in reset", {31'h0, ampOutputOe}, 32'h0);
      @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("trim after reset", {26'h0, ampCtrl.trim}, 32'h20);
      @(posedge clk);
      testRegisters();
      testSearch();
      finish_test();
   end

endmodule
